// ===== rtl/fwr_defs.svh
// Purpose: Constants of the fault waveform recorder
// Assumes: Byte addresses on the plain register port
// Notes:   Definitions only
`ifndef FWR_DEFS_SVH
`define FWR_DEFS_SVH

`define FWR_SPC            32
`define FWR_TOTAL_CYC      750
`define FWR_MAX_RECS       64
`define FWR_MAX_LEN_CYC    725
`define FWR_ONE_REC_CYC    350
`define FWR_PRE_MAX        25
`define FWR_POST_MIN       5
`define FWR_IVL_MIN        1
`define FWR_NSRC           27
`define FWR_EXT_BIT        24

`define FWR_A_CTRL         8'h00
`define FWR_A_PRE          8'h04
`define FWR_A_POST         8'h08
`define FWR_A_IVL          8'h0c
`define FWR_A_MASK         8'h10
`define FWR_A_AEN          8'h14
`define FWR_A_USER         8'h18
`define FWR_A_STAT         8'h1c
`define FWR_A_RSEL         8'h20
`define FWR_A_RTS          8'h24
`define FWR_A_RINFO        8'h28
`define FWR_A_MADDR        8'h2c
`define FWR_A_MDATA        8'h30

`define FWR_B_TRIPREQ      0
`define FWR_B_CONT         1
`define FWR_B_SWEN         2
`define FWR_B_SINE         8

`define FWR_RST_CTRL       3'h5
`define FWR_RST_PRE        5'h05
`define FWR_RST_POST       10'h005
`define FWR_RST_IVL        10'h004
`define FWR_RST_MASK       27'h1000000
`define FWR_RST_AEN        15'h7fff

`endif

// ===== rtl/fwr_pkg.sv
// Purpose: Types of the fault waveform recorder
// Assumes: Constants live in fwr_defs.svh
// Notes:   Types only
package fwr_pkg;
	typedef enum logic [0:0] {
		FWR_IDLE = 1'b0,
		FWR_CAPT = 1'b1
	} fwr_state_t;
endpackage

// ===== rtl/fwr_recorder.sv
// Purpose: Fault waveform recorder core with record store and register port
// Assumes: SAMPLE_TICK pulses once per sample, 32 ticks per power cycle
// Notes:   Record store and pre-trigger ring are plain arrays
`timescale 1ns/1ps
`include "fwr_defs.svh"
`default_nettype none

module fwr_recorder
	import fwr_pkg::*;
#(
	parameter int NAN  = 15,
	parameter int AW   = 16,
	parameter int NDIG = 80,
	parameter int UW   = 16,
	parameter int NUSR = 5
) (
	input  wire logic                  MCLK,
	input  wire logic                  RESET,
	input  wire logic                  SAMPLE_TICK,
	input  wire logic [NAN*AW-1:0]     ANALOG_IN,
	input  wire logic [NUSR*UW-1:0]    USER_VAL,
	input  wire logic [NUSR*UW-1:0]    USER_RMS,
	input  wire logic [NDIG-1:0]       DIGITAL_IN,
	input  wire logic [`FWR_NSRC-1:0]  PICKUP,
	input  wire logic                  EXTERNAL_CAPTURE_TRIGGER,
	input  wire logic                  TRIP,
	input  wire logic [31:0]           TIMESTAMP,
	input  wire logic                  DELETE_ALL_RECORDS,
	input  wire logic                  LOGIC_LOAD,
	input  wire logic                  RECORDER_ENABLE_INPUT,
	input  wire logic [7:0]            ADDR,
	input  wire logic [31:0]           WDATA,
	input  wire logic                  WR,
	input  wire logic                  RD,
	output logic      [31:0]           RDATA,
	output logic                       CAPTURING,
	output logic                       RECORD_DONE
);
	localparam int RW    = NAN*AW + NDIG;
	localparam int NWORD = (RW + 31) / 32;
	localparam int MROWS = `FWR_TOTAL_CYC * `FWR_SPC;
	localparam int RROWS = `FWR_PRE_MAX * `FWR_SPC;

	function automatic logic [9:0] clamp10(input logic [9:0] v, input logic [9:0] lo,
		input logic [9:0] hi);
		clamp10 = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction

	function automatic logic [14:0] zone_base(input logic [5:0] z, input logic [14:0] zr);
		logic [20:0] p;
		p = 21'(z) * 21'(zr);
		zone_base = p[14:0];
	endfunction

	function automatic logic [14:0] cyc_rows(input logic [9:0] c);
		logic [14:0] p;
		p = 15'(c) * 15'(`FWR_SPC);
		cyc_rows = p;
	endfunction

	// Settings
	logic [2:0]            ctrl_r;
	logic [4:0]            pre_r;
	logic [9:0]            post_r;
	logic [9:0]            ivl_r;
	logic [`FWR_NSRC-1:0]  mask_r;
	logic [NAN-1:0]        aen_r;
	logic [2:0]            ucnt_r;
	logic [NUSR-1:0]       usine_r;
	logic [5:0]            rsel_r;
	logic [19:0]           maddr_r;

	// Capture state
	fwr_state_t            state_r;
	logic [14:0]           wcnt_r;
	logic [14:0]           target_r;
	logic [14:0]           since_r;
	logic                  trip_seen_r;
	logic [`FWR_NSRC-1:0]  init_r;
	logic [`FWR_NSRC-1:0]  src_d_r;
	logic [31:0]           ts_r;
	logic [9:0]            ring_wp_r;

	// Record table
	logic [5:0]            head_r;
	logic [6:0]            count_r;
	logic [6:0]            nzones_r;
	logic [`FWR_MAX_RECS-1:0] valid_r;
	logic [31:0]           rec_ts_r   [`FWR_MAX_RECS];
	logic [14:0]           rec_rows_r [`FWR_MAX_RECS];

	logic [RW-1:0]         mem  [MROWS];
	logic [RW-1:0]         ring [RROWS];

	logic                  en;
	logic                  set_wr;
	logic                  erase;
	logic [`FWR_NSRC-1:0]  src;
	logic [`FWR_NSRC-1:0]  rise;
	logic                  start;
	logic                  ext_ok;
	logic                  finish;
	logic                  keep;
	logic [RW-1:0]         row_cur;
	logic [RW-1:0]         row_del;
	logic [14:0]           pre_rows;
	logic [14:0]           post_rows;
	logic [14:0]           zone_rows;
	logic [14:0]           base;
	logic [9:0]            rp;
	logic [9:0]            nz_div;
	logic [14:0]           zr_div;

	assign en     = RECORDER_ENABLE_INPUT & ctrl_r[`FWR_B_SWEN];
	assign set_wr = WR && (ADDR <= `FWR_A_USER);
	assign erase  = DELETE_ALL_RECORDS | LOGIC_LOAD | set_wr;

	// External trigger takes its own mask slot
	always_comb begin
		src = PICKUP;
		src[`FWR_EXT_BIT] = EXTERNAL_CAPTURE_TRIGGER;
	end
	assign rise  = (src & mask_r) & ~src_d_r;
	assign start = SAMPLE_TICK && en && !erase && state_r == FWR_IDLE && |rise;

	assign pre_rows  = cyc_rows({5'h00, pre_r});
	assign post_rows = cyc_rows(post_r);

	// Zone count follows the length setting
	always_comb begin
		nz_div = 10'(`FWR_MAX_LEN_CYC) / post_r;
		zr_div = 15'(MROWS / (nzones_r == 7'h00 ? 1 : int'(nzones_r)));
	end
	assign zone_rows = zr_div;
	assign base      = zone_base(head_r, zone_rows);

	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			nzones_r <= 7'(`FWR_MAX_RECS);
		end else if (post_r > 10'(`FWR_ONE_REC_CYC)) begin
			nzones_r <= 7'h01;
		end else if (nz_div > 10'(`FWR_MAX_RECS)) begin
			nzones_r <= 7'(`FWR_MAX_RECS);
		end else begin
			nzones_r <= nz_div[6:0];
		end
	end

	// Sample row: analog, then derived values over the low digital slots
	genvar gi;
	generate
		for (gi = 0; gi < NAN; gi++) begin : g_an
			assign row_cur[gi*AW +: AW] = aen_r[gi] ? ANALOG_IN[gi*AW +: AW] : '0;
		end
		for (gi = 0; gi < NDIG/UW; gi++) begin : g_dg
			if (gi < NUSR) begin : g_usr
				assign row_cur[NAN*AW + gi*UW +: UW] = (3'(gi) < ucnt_r)
					? (usine_r[gi] ? USER_RMS[gi*UW +: UW] : USER_VAL[gi*UW +: UW])
					: DIGITAL_IN[gi*UW +: UW];
			end else begin : g_dig
				assign row_cur[NAN*AW + gi*UW +: UW] = DIGITAL_IN[gi*UW +: UW];
			end
		end
	endgenerate

	// Delayed tap gives the pre-trigger history
	assign rp = (ring_wp_r >= pre_rows[9:0]) ? ring_wp_r - pre_rows[9:0]
		: 10'(int'(ring_wp_r) + RROWS - int'(pre_rows));
	assign row_del = (pre_r == 5'h00) ? row_cur : ring[rp];

	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			ring_wp_r <= 10'h000;
		end else if (SAMPLE_TICK && en) begin
			ring_wp_r <= (ring_wp_r == 10'(RROWS - 1)) ? 10'h000 : ring_wp_r + 10'h001;
		end
	end

	always_ff @(posedge MCLK) begin
		if (SAMPLE_TICK && en) begin
			ring[ring_wp_r] <= row_cur;
		end
	end

	always_ff @(posedge MCLK) begin
		if (SAMPLE_TICK && state_r == FWR_CAPT && !erase) begin
			mem[base + wcnt_r] <= row_del;
		end
	end

	// Capture ends at target or when the zone is full
	assign finish = SAMPLE_TICK && en && state_r == FWR_CAPT &&
		(wcnt_r + 15'h0001 >= target_r || wcnt_r + 15'h0001 >= zone_rows);
	assign keep = !ctrl_r[`FWR_B_TRIPREQ] || trip_seen_r || TRIP;
	assign ext_ok = |rise && |(src & init_r) && ctrl_r[`FWR_B_CONT]
		&& since_r >= cyc_rows(ivl_r);

	// Edge judged tick to tick, so a pickup rising between ticks is not lost
	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			src_d_r <= '0;
		end else if (SAMPLE_TICK) begin
			src_d_r <= src & mask_r;
		end
	end

	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			state_r     <= FWR_IDLE;
			wcnt_r      <= 15'h0000;
			target_r    <= 15'h0000;
			since_r     <= 15'h0000;
			trip_seen_r <= 1'b0;
			init_r      <= '0;
			ts_r        <= 32'h0000_0000;
		end else if (erase || !en) begin
			state_r <= FWR_IDLE;
		end else if (start) begin
			state_r     <= FWR_CAPT;
			wcnt_r      <= 15'h0000;
			target_r    <= pre_rows + post_rows;
			since_r     <= 15'h0000;
			trip_seen_r <= TRIP;
			init_r      <= rise;
			ts_r        <= TIMESTAMP;
		end else if (SAMPLE_TICK && state_r == FWR_CAPT) begin
			wcnt_r  <= wcnt_r + 15'h0001;
			since_r <= since_r + 15'h0001;
			if (TRIP) begin
				trip_seen_r <= 1'b1;
			end
			if (finish) begin
				state_r <= FWR_IDLE;
			end else if (ext_ok) begin
				target_r <= wcnt_r + pre_rows + post_rows;
				since_r  <= 15'h0000;
			end
		end
	end

	// Record table; erase wins since it voids the store itself
	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			head_r  <= 6'h00;
			count_r <= 7'h00;
			valid_r <= '0;
		end else if (erase) begin
			head_r  <= 6'h00;
			count_r <= 7'h00;
			valid_r <= '0;
		end else if (finish && keep) begin
			valid_r[head_r] <= 1'b1;
			head_r  <= (7'(head_r) + 7'h01 >= nzones_r) ? 6'h00 : head_r + 6'h01;
			if (count_r < nzones_r) begin
				count_r <= count_r + 7'h01;
			end
		end
	end

	always_ff @(posedge MCLK) begin
		if (finish && keep && !erase) begin
			rec_ts_r[head_r]   <= ts_r;
			rec_rows_r[head_r] <= wcnt_r + 15'h0001;
		end
	end

	// Settings writes, clamped to their legal ranges
	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			ctrl_r  <= `FWR_RST_CTRL;
			pre_r   <= `FWR_RST_PRE;
			post_r  <= `FWR_RST_POST;
			ivl_r   <= `FWR_RST_IVL;
			mask_r  <= `FWR_RST_MASK;
			aen_r   <= `FWR_RST_AEN;
			ucnt_r  <= 3'h0;
			usine_r <= '0;
			rsel_r  <= 6'h00;
			maddr_r <= 20'h00000;
		end else if (WR) begin
			case (ADDR)
				`FWR_A_CTRL: begin
					ctrl_r <= WDATA[2:0];
				end
				`FWR_A_PRE: begin
					pre_r <= (WDATA[4:0] > 5'(`FWR_PRE_MAX)) ? 5'(`FWR_PRE_MAX) : WDATA[4:0];
				end
				`FWR_A_POST: begin
					post_r <= clamp10(WDATA[9:0], 10'(`FWR_POST_MIN), 10'(`FWR_MAX_LEN_CYC));
				end
				`FWR_A_IVL: begin
					ivl_r <= clamp10(WDATA[9:0], 10'(`FWR_IVL_MIN), 10'(`FWR_MAX_LEN_CYC));
				end
				`FWR_A_MASK: begin
					mask_r <= WDATA[`FWR_NSRC-1:0];
				end
				`FWR_A_AEN: begin
					aen_r <= WDATA[NAN-1:0];
				end
				`FWR_A_USER: begin
					ucnt_r  <= (WDATA[2:0] > 3'(NUSR)) ? 3'(NUSR) : WDATA[2:0];
					usine_r <= WDATA[`FWR_B_SINE +: NUSR];
				end
				`FWR_A_RSEL: begin
					rsel_r <= WDATA[5:0];
				end
				`FWR_A_MADDR: begin
					maddr_r <= WDATA[19:0];
				end
				default: begin
				end
			endcase
		end
	end

	// Read port: data only in the cycle after the strobe
	logic [RW-1:0]  mrow;
	logic [14:0]    maddr_abs;
	logic [31:0]    mword;
	logic [31:0]    rd_nxt;

	assign maddr_abs = zone_base(rsel_r, zone_rows) + maddr_r[14:0];
	assign mrow      = mem[maddr_abs];

	always_comb begin
		mword = 32'h0000_0000;
		for (int w = 0; w < NWORD; w++) begin
			if (maddr_r[19:16] == 4'(w)) begin
				for (int b = 0; b < 32; b++) begin
					if (w*32 + b < RW) begin
						mword[b] = mrow[w*32 + b];
					end
				end
			end
		end
	end

	always_comb begin
		rd_nxt = 32'h0000_0000;
		case (ADDR)
			`FWR_A_CTRL:  rd_nxt = {29'h0, ctrl_r};
			`FWR_A_PRE:   rd_nxt = {27'h0, pre_r};
			`FWR_A_POST:  rd_nxt = {22'h0, post_r};
			`FWR_A_IVL:   rd_nxt = {22'h0, ivl_r};
			`FWR_A_MASK:  rd_nxt = 32'(mask_r);
			`FWR_A_AEN:   rd_nxt = 32'(aen_r);
			`FWR_A_USER:  rd_nxt = 32'(ucnt_r) | (32'(usine_r) << `FWR_B_SINE);
			`FWR_A_STAT:  rd_nxt = {1'b0, nzones_r, 2'h0, head_r, 1'b0, count_r,
				6'h00, en, state_r == FWR_CAPT};
			`FWR_A_RSEL:  rd_nxt = {26'h0, rsel_r};
			`FWR_A_RTS:   rd_nxt = valid_r[rsel_r] ? rec_ts_r[rsel_r] : 32'h0000_0000;
			`FWR_A_RINFO: rd_nxt = {valid_r[rsel_r], 16'h0000,
				valid_r[rsel_r] ? rec_rows_r[rsel_r] : 15'h0000};
			`FWR_A_MADDR: rd_nxt = {12'h000, maddr_r};
			`FWR_A_MDATA: rd_nxt = mword;
			default:      rd_nxt = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			RDATA <= 32'h0000_0000;
		end else begin
			RDATA <= RD ? rd_nxt : 32'h0000_0000;
		end
	end

	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			RECORD_DONE <= 1'b0;
		end else begin
			RECORD_DONE <= finish && keep && !erase && en;
		end
	end

	assign CAPTURING = (state_r == FWR_CAPT);
endmodule

`default_nettype wire

// ===== tb/fwr_front.sv
// Purpose: Sampling front end model feeding the recorder
// Assumes: One sample tick every second clock
// Notes:   Sample data is random so stale rows show up
`timescale 1ns/1ps
`default_nettype none

module fwr_front (
	input  wire logic    MCLK,
	input  wire logic    RESET,
	output logic         SAMPLE_TICK,
	output logic [239:0] ANALOG_IN,
	output logic [79:0]  USER_VAL,
	output logic [79:0]  USER_RMS,
	output logic [79:0]  DIGITAL_IN,
	output logic [31:0]  TIMESTAMP
);
	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			SAMPLE_TICK <= 1'b0;
			TIMESTAMP   <= 32'h0;
			ANALOG_IN   <= 240'h0;
			USER_VAL    <= 80'h0;
			USER_RMS    <= 80'h0;
			DIGITAL_IN  <= 80'h0;
		end else begin
			SAMPLE_TICK <= !SAMPLE_TICK;
			// New sample and time only with a tick, held while it stands
			if (!SAMPLE_TICK) begin
				TIMESTAMP  <= TIMESTAMP + 32'h1;
				ANALOG_IN  <= 240'({8{$urandom()}});
				USER_VAL   <= 80'({3{$urandom()}});
				USER_RMS   <= 80'({3{$urandom()}});
				DIGITAL_IN <= 80'({3{$urandom()}});
			end
		end
	end
endmodule
`default_nettype wire

// ===== tb/fwr_recorder_props.sv
// Purpose: Port assertions for the fault waveform recorder
// Assumes: One clock MCLK, RESET asynchronous active high
// Notes:   Bound into fwr_recorder
`timescale 1ns/1ps
`include "fwr_defs.svh"
`default_nettype none

module fwr_recorder_props (
	input wire logic                 MCLK,
	input wire logic                 RESET,
	input wire logic                 SAMPLE_TICK,
	input wire logic [`FWR_NSRC-1:0] PICKUP,
	input wire logic                 EXTERNAL_CAPTURE_TRIGGER,
	input wire logic                 DELETE_ALL_RECORDS,
	input wire logic                 LOGIC_LOAD,
	input wire logic                 RECORDER_ENABLE_INPUT,
	input wire logic [7:0]           ADDR,
	input wire logic                 WR,
	input wire logic                 RD,
	input wire logic [31:0]          RDATA,
	input wire logic                 CAPTURING,
	input wire logic                 RECORD_DONE
);
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (RESET);

	sequence cap_start_s;
		$rose(CAPTURING);
	endsequence

	sequence quiet_s;
		!$past(SAMPLE_TICK) && !$past(WR) && !$past(DELETE_ALL_RECORDS)
			&& !$past(LOGIC_LOAD) && $past(RECORDER_ENABLE_INPUT);
	endsequence

	rd_idle_a: assert property (!$past(RD) |-> RDATA == 32'h0)
		else $error("read data not zero outside read cycle");
	start_tick_a: assert property (cap_start_s |-> $past(SAMPLE_TICK))
		else $error("capture started without sample tick");
	start_source_a: assert property (cap_start_s |-> $past((|PICKUP) | EXTERNAL_CAPTURE_TRIGGER))
		else $error("capture started with no source high");
	start_enable_a: assert property (cap_start_s |-> $past(RECORDER_ENABLE_INPUT))
		else $error("capture started while disabled");
	start_erase_a: assert property (cap_start_s |-> !$past(DELETE_ALL_RECORDS))
		else $error("capture started during delete");
	setting_abort_a: assert property (WR && ADDR <= `FWR_A_USER |=> !CAPTURING)
		else $error("capture survived a setting write");
	capture_hold_a: assert property (quiet_s |-> $stable(CAPTURING))
		else $error("capture state moved between ticks");
	done_pulse_a: assert property (RECORD_DONE |=> !RECORD_DONE)
		else $error("record done longer than one cycle");
	done_after_a: assert property (RECORD_DONE |-> !CAPTURING
		&& ($past(CAPTURING) || $past(CAPTURING, 2)))
		else $error("record done without a finished capture");
endmodule

bind fwr_recorder fwr_recorder_props u_props (.MCLK(MCLK), .RESET(RESET),
	.SAMPLE_TICK(SAMPLE_TICK), .PICKUP(PICKUP),
	.EXTERNAL_CAPTURE_TRIGGER(EXTERNAL_CAPTURE_TRIGGER),
	.DELETE_ALL_RECORDS(DELETE_ALL_RECORDS), .LOGIC_LOAD(LOGIC_LOAD),
	.RECORDER_ENABLE_INPUT(RECORDER_ENABLE_INPUT), .ADDR(ADDR), .WR(WR), .RD(RD),
	.RDATA(RDATA), .CAPTURING(CAPTURING), .RECORD_DONE(RECORD_DONE));
`default_nettype wire

// ===== tb/fwr_recorder_tb.sv
// Purpose: Self-checking bench of the fault waveform recorder
// Assumes: Ticks every second clock, register port without wait
// Notes:   Lengths checked within a few clocks of the tick grid
`timescale 1ns/1ps
`default_nettype none

module fwr_recorder_tb;
	logic         mclk;
	logic         reset;
	logic         tick;
	logic [239:0] ana;
	logic [79:0]  uval;
	logic [79:0]  urms;
	logic [79:0]  dig;
	logic [31:0]  ts;
	logic [26:0]  src;
	logic         trip;
	logic         del;
	logic         load;
	logic         en;
	logic [7:0]   addr;
	logic [31:0]  wdata;
	logic         wr;
	logic         rd;
	logic [31:0]  rdata;
	logic         capt;
	logic         done;
	logic         hung;
	logic         dn;
	logic         mk;
	logic [31:0]  d;
	logic [31:0]  t0;
	int           n_mismatch;
	int           checked;
	int           cnt;
	int           n;
	int           i;
	int           s;
	logic [31:0]  rv [7] = '{32'h5, 32'h5, 32'h5, 32'h4, 32'h1000000, 32'h7fff, 32'h0};
	logic [31:0]  pl [7] = '{32'h2, 32'hb, 32'h16, 32'haf, 32'h15e, 32'h15f, 32'h320};
	logic [31:0]  iv [3] = '{32'h1, 32'h4, 32'h1};
	logic [31:0]  ct [3] = '{32'h6, 32'h6, 32'h4};

	fwr_front fe (.MCLK(mclk), .RESET(reset), .SAMPLE_TICK(tick), .ANALOG_IN(ana),
		.USER_VAL(uval), .USER_RMS(urms), .DIGITAL_IN(dig), .TIMESTAMP(ts));

	fwr_recorder uut (.MCLK(mclk), .RESET(reset), .SAMPLE_TICK(tick), .ANALOG_IN(ana),
		.USER_VAL(uval), .USER_RMS(urms), .DIGITAL_IN(dig), .PICKUP(src),
		.EXTERNAL_CAPTURE_TRIGGER(src[24]), .TRIP(trip), .TIMESTAMP(ts),
		.DELETE_ALL_RECORDS(del), .LOGIC_LOAD(load), .RECORDER_ENABLE_INPUT(en),
		.ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
		.CAPTURING(capt), .RECORD_DONE(done));

	function automatic logic [31:0] zexp(input logic [31:0] p);
		logic [31:0] c;
		c = (p < 32'h5) ? 32'h5 : (p > 32'h2d5) ? 32'h2d5 : p;
		return (c > 32'h15e) ? 32'h1 : (32'h2d5 / c > 32'h40) ? 32'h40 : 32'h2d5 / c;
	endfunction

	function automatic logic in_len(input int c, input int l);
		return c >= 2 * l - 3 && c <= 2 * l + 3;
	endfunction

	task automatic chk(input string nm, input logic [31:0] sn, input logic [31:0] ex);
		checked++;
		if (sn !== ex) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, ex, sn);
		end
	endtask

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Gap cycle after each strobe keeps one assignment per time step
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
		@(posedge mclk);
	endtask

	task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1;
		v = rdata;
		@(posedge mclk);
	endtask

	task automatic chk_cnt(input int e);
		rd_reg(8'h1c, d);
		chk("record count", 32'(d[14:8]), 32'(e));
	endtask

	// Initiator held for the whole capture so a late pickup can concatenate
	task automatic cap(input int b, input int x);
		int k;
		n = 0;
		dn = 1'b0;
		src[b] <= 1'b1;
		for (k = 0; k < 5000; k++) begin
			@(posedge mclk);
			if (k == x)
				src[4] <= 1'b1;
			#1;
			dn = dn | done;
			if (capt === 1'b1) begin
				if (n == 0)
					t0 = ts;
				n++;
			end else if (k > n + 8)
				break;
		end
		if (k == 5000) begin
			n_mismatch++;
			hung = 1'b1;
		end
		// Low over two clocks so a sample tick sees the pickup drop
		@(posedge mclk);
		src <= 27'h0;
		repeat (2) @(posedge mclk);
	endtask

	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	always @(posedge mclk) if (hung) tally_and_finish();

	initial begin
		{reset, en} = 2'h3;
		{src, trip, del, load, wr, rd, hung, addr, wdata} = '0;
		{n_mismatch, checked, cnt} = '0;
		repeat (10) @(posedge mclk);
		reset <= 1'b0;
		@(posedge mclk);
		void'($urandom(95));
		for (i = 0; i < 7; i++) begin
			rd_reg(8'(4 * i), d);
			chk("reset setting", d, rv[i]);
		end
		rd_reg(8'h1c, d);
		chk("enable and zones", 32'({d[30:24], d[1]}), 32'h81);
		rd_reg(8'h40, d);
		chk("unmapped read", d, 32'h0);
		wr_reg(8'h04, 32'h1e);
		rd_reg(8'h04, d);
		chk("pre clamp", d, 32'h19);
		for (i = 0; i < 7; i++) begin
			wr_reg(8'h08, pl[i]);
			rd_reg(8'h1c, d);
			chk("zones", 32'(d[30:24]), zexp(pl[i]));
		end
		wr_reg(8'h04, 32'h0);
		wr_reg(8'h08, 32'h5);
		wr_reg(8'h10, 32'h1000018);
		wr_reg(8'h00, 32'h4);
		$display("settings test done");
		for (i = 0; i < 8; i++) begin
			s = (i == 0) ? 24 : (i == 1) ? 3 : $urandom_range(26, 0);
			cap(s, -1);
			mk = (s == 3 || s == 4 || s == 24);
			cnt += mk;
			chk("masked start", 32'(n > 0), 32'(mk));
			chk("record kept", 32'(dn), 32'(mk));
			if (mk)
				chk("length", 32'(in_len(n, 160)), 32'h1);
			chk_cnt(cnt);
		end
		del <= 1'b1;
		@(posedge mclk);
		del <= 1'b0;
		@(posedge mclk);
		chk_cnt(0);
		wr_reg(8'h00, 32'h5);
		cap(3, -1);
		chk("no trip discard", 32'(dn), 32'h0);
		trip <= 1'b1;
		cap(3, -1);
		chk("trip kept", 32'(dn), 32'h1);
		chk_cnt(1);
		rd_reg(8'h24, d);
		chk("record timestamp", d, t0);
		rd_reg(8'h28, d);
		chk("record rows", d, 32'h800000a0);
		load <= 1'b1;
		@(posedge mclk);
		load <= 1'b0;
		@(posedge mclk);
		chk_cnt(0);
		en <= 1'b0;
		cap(3, -1);
		chk("disabled start", 32'(n), 32'h0);
		en <= 1'b1;
		$display("trigger test done");
		for (i = 0; i < 3; i++) begin
			wr_reg(8'h0c, iv[i]);
			wr_reg(8'h00, ct[i]);
			cap(3, 150);
			chk("extended", 32'(n > 340), 32'(i == 0));
		end
		wr_reg(8'h08, 32'h16);
		wr_reg(8'h00, 32'h4);
		for (i = 0; i < 33; i++)
			cap(3, -1);
		chk_cnt(32);
		chk("head wrap", 32'(d[21:16]), 32'h1);
		$display("store test done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
